// >>> rtl/fpsq_pkg.sv
// Overview of operation
// - The integer-word store is primary opcode 31 with extended opcode 983, fp source in bits 6-10, base in 11-15, index in 16-20.
// - The integer-word store writes the low 32 bits of the fp source register, unconverted, to the word at the effective address.
// - The integer-word store address is base plus index, or the index alone when the base field is zero.
// - A source last written by single-precision work may store an undefined word; the unit stores the low half regardless.
// - None of these stores touch the fp status and control register or condition field 0.
// - Quad stores decode as opcode 60 with low bits 00, opcode 61 with low bits 01, or opcode 31 with extended opcode 951.
// - Displacement quad forms sign-extend the 14-bit displacement to 30 bits and append two zero bits.
// - Displacement quad address is the offset alone when the base field is zero, else offset plus base.
// - A quad store writes the named register at the address and the next register, wrapping 31 to 0, eight bytes higher.
// - Update quad forms write the address back into the base register when the base field is nonzero.
// - The indexed-update quad address is base plus index, or the index alone when the base field is zero.
// - Base write-back happens only for a nonzero base field and an access that raised no fault.
package fpsq_pkg;
	localparam int unsigned FPSQ_XLEN = 32;
	localparam int unsigned FPSQ_FLEN = 64;
	typedef logic [FPSQ_XLEN-1:0] fpsq_addr_t;
	typedef logic [FPSQ_FLEN-1:0] fpsq_fdata_t;
	typedef logic [4:0] fpsq_ridx_t;
	// Field positions, little-endian numbering of the 32-bit word
	localparam int unsigned FPSQ_OPC_LSB = 26;
	localparam int unsigned FPSQ_FRS_LSB = 21;
	localparam int unsigned FPSQ_BASE_LSB = 16;
	localparam int unsigned FPSQ_INDEX_LSB = 11;
	localparam int unsigned FPSQ_XO_LSB = 1;
	localparam int unsigned FPSQ_DS_LSB = 2;
	localparam int unsigned FPSQ_DS_W = 14;
	// Encodings
	localparam logic [5:0] FPSQ_OPC_EXT = 6'h1F;
	localparam logic [5:0] FPSQ_OPC_QD = 6'h3C;
	localparam logic [5:0] FPSQ_OPC_QDU = 6'h3D;
	localparam logic [9:0] FPSQ_XO_IWX = 10'h3D7;
	localparam logic [9:0] FPSQ_XO_QUX = 10'h3B7;
	localparam logic [1:0] FPSQ_SUB_QD = 2'h0;
	localparam logic [1:0] FPSQ_SUB_QDU = 2'h1;
	// Address step to the second doubleword
	localparam fpsq_addr_t FPSQ_DW_STEP = 32'h0000_0008;
	// Reset values
	localparam fpsq_addr_t FPSQ_ADDR_RST = 32'h0000_0000;
	localparam fpsq_fdata_t FPSQ_DATA_RST = 64'h0000_0000_0000_0000;
	localparam logic [31:0] FPSQ_INSTR_RST = 32'h0000_0000;
	typedef enum logic [1:0] {
		FPSQ_OP_NONE,
		FPSQ_OP_IWX,
		FPSQ_OP_QUAD
	} fpsq_op_e;
	typedef enum {
		FPSQ_IDLE,
		FPSQ_CALC,
		FPSQ_ST0,
		FPSQ_ST1,
		FPSQ_FIN
	} fpsq_state_e;
endpackage : fpsq_pkg

// >>> rtl/fpsq_dec_if.sv
`timescale 1ns/10ps
interface fpsq_dec_if;
	import fpsq_pkg::*;
	logic [31:0] instr;
	fpsq_op_e op;
	logic upd;
	logic disp;
	fpsq_ridx_t fp_source_reg_field;
	fpsq_ridx_t base;
	fpsq_ridx_t index;
	fpsq_addr_t offset;
	modport dec (input instr, output op, upd, disp, fp_source_reg_field, base, index, offset);
	modport core (output instr, input op, upd, disp, fp_source_reg_field, base, index, offset);
endinterface : fpsq_dec_if

// >>> rtl/fpsq_decode.sv
`timescale 1ns/10ps
module fpsq_decode (
	// Decoded instruction
	fpsq_dec_if.dec d
);
	import fpsq_pkg::*;
	logic [5:0] opc;
	logic [9:0] xo;
	logic [1:0] sub;
	logic [FPSQ_DS_W-1:0] ds;
	assign opc = d.instr[FPSQ_OPC_LSB +: 6];
	assign xo = d.instr[FPSQ_XO_LSB +: 10];
	assign sub = d.instr[1:0];
	assign ds = d.instr[FPSQ_DS_LSB +: FPSQ_DS_W];
	assign d.fp_source_reg_field = d.instr[FPSQ_FRS_LSB +: 5];
	assign d.base = d.instr[FPSQ_BASE_LSB +: 5];
	assign d.index = d.instr[FPSQ_INDEX_LSB +: 5];
	// Sign-extend to 30 bits, then two zero bits
	assign d.offset = {{(FPSQ_XLEN-FPSQ_DS_W-2){ds[FPSQ_DS_W-1]}}, ds,
		2'b00};
	always_comb begin
		d.op = FPSQ_OP_NONE;
		d.upd = 1'b0;
		d.disp = 1'b0;
		if (opc == FPSQ_OPC_EXT && xo == FPSQ_XO_IWX) begin
			d.op = FPSQ_OP_IWX;
		end else if (opc == FPSQ_OPC_EXT && xo == FPSQ_XO_QUX) begin
			d.op = FPSQ_OP_QUAD;
			d.upd = 1'b1;
		end else if (opc == FPSQ_OPC_QD && sub == FPSQ_SUB_QD) begin
			d.op = FPSQ_OP_QUAD;
			d.disp = 1'b1;
		end else if (opc == FPSQ_OPC_QDU && sub == FPSQ_SUB_QDU) begin
			d.op = FPSQ_OP_QUAD;
			d.disp = 1'b1;
			d.upd = 1'b1;
		end
	end
endmodule : fpsq_decode

// >>> rtl/fpsq_unit.sv
`timescale 1ns/10ps
module fpsq_unit (
	// Clock and reset
	input wire logic CLK_SYS,
	input wire logic RST_N,
	// Instruction issue
	input wire logic ISSUE_VALID,
	output logic ISSUE_READY,
	input wire logic [31:0] ISSUE_INSTR,
	// General register read ports
	output fpsq_pkg::fpsq_ridx_t GPR_BASE_IDX,
	input wire fpsq_pkg::fpsq_addr_t GPR_BASE_DATA,
	output fpsq_pkg::fpsq_ridx_t GPR_INDEX_IDX,
	input wire fpsq_pkg::fpsq_addr_t GPR_INDEX_DATA,
	// Floating-point register read ports
	output fpsq_pkg::fpsq_ridx_t FPR_RD0_IDX,
	input wire fpsq_pkg::fpsq_fdata_t FPR_RD0_DATA,
	output fpsq_pkg::fpsq_ridx_t FPR_RD1_IDX,
	input wire fpsq_pkg::fpsq_fdata_t FPR_RD1_DATA,
	// Store port
	output logic STORE_VALID,
	input wire logic STORE_READY,
	input wire logic STORE_FAULT,
	output fpsq_pkg::fpsq_addr_t STORE_ADDR,
	output fpsq_pkg::fpsq_fdata_t STORE_DATA,
	output logic STORE_WORD,
	// Base register write-back
	output logic GPR_WE,
	output fpsq_pkg::fpsq_ridx_t GPR_WR_IDX,
	output fpsq_pkg::fpsq_addr_t GPR_WR_DATA,
	// Completion
	output logic DONE,
	output logic DONE_FAULT,
	output logic DONE_ILLEGAL
);
	import fpsq_pkg::*;

	fpsq_dec_if dif ();
	fpsq_state_e state_q, state_d;
	logic [31:0] instr_q;
	fpsq_addr_t ea_q;
	fpsq_addr_t addr_q;
	fpsq_fdata_t data_q;
	fpsq_fdata_t data2_q;
	logic word_q;
	logic fault_q;
	fpsq_addr_t base_val;
	fpsq_addr_t ea_d;
	logic accept;
	// Store beat qualifiers
	logic beat_take;
	logic beat_ok;
	logic quad;
	logic first_ok;
	logic fin;

	// Decoder works on the held instruction
	assign dif.instr = instr_q;
	fpsq_decode u_dec (
		.d(dif)
	);

	// Issue is open only while idle
	assign ISSUE_READY = (state_q == FPSQ_IDLE);
	assign accept = ISSUE_VALID && ISSUE_READY;
	assign GPR_BASE_IDX = dif.base;
	assign GPR_INDEX_IDX = dif.index;
	assign FPR_RD0_IDX = dif.fp_source_reg_field;
	// Five-bit index wraps 31 to 0
	assign FPR_RD1_IDX = fpsq_ridx_t'(dif.fp_source_reg_field + 5'h01);

	// Base field zero means literal zero, not register 0
	assign base_val = (dif.base == 5'h00) ? FPSQ_ADDR_RST
		: GPR_BASE_DATA;
	assign ea_d = base_val + (dif.disp ? dif.offset
		: GPR_INDEX_DATA);

	// One instruction at a time; issue reopens the cycle after completion
	always_comb begin
		state_d = state_q;
		unique case (state_q)
			FPSQ_IDLE: begin
				if (accept) begin
					state_d = FPSQ_CALC;
				end
			end
			FPSQ_CALC: begin
				if (dif.op == FPSQ_OP_NONE) begin
					state_d = FPSQ_FIN;
				end else begin
					state_d = FPSQ_ST0;
				end
			end
			FPSQ_ST0: begin
				if (STORE_READY) begin
					// A faulting first write cancels the second
					if (STORE_FAULT || dif.op != FPSQ_OP_QUAD) begin
						state_d = FPSQ_FIN;
					end else begin
						state_d = FPSQ_ST1;
					end
				end
			end
			FPSQ_ST1: begin
				if (STORE_READY) begin
					state_d = FPSQ_FIN;
				end
			end
			FPSQ_FIN: begin
				state_d = FPSQ_IDLE;
			end
		endcase
	end

	always_ff @(posedge CLK_SYS) begin
		if (!RST_N) begin
			state_q <= FPSQ_IDLE;
		end else begin
			state_q <= state_d;
		end
	end

	// Held to the end so that decode stays valid for write-back
	always_ff @(posedge CLK_SYS) begin
		if (!RST_N) begin
			instr_q <= FPSQ_INSTR_RST;
		end else if (accept) begin
			instr_q <= ISSUE_INSTR;
		end
	end

	// A quad moves to its second beat only after a clean first beat
	assign beat_take = STORE_VALID && STORE_READY;
	assign beat_ok = beat_take && !STORE_FAULT;
	assign quad = (dif.op == FPSQ_OP_QUAD);
	assign first_ok = (state_q == FPSQ_ST0) && beat_ok && quad;
	assign fin = (state_q == FPSQ_FIN);

	// Effective address, kept for the second beat and the write-back
	always_ff @(posedge CLK_SYS) begin
		if (!RST_N) begin
			ea_q <= FPSQ_ADDR_RST;
		end else if (state_q == FPSQ_CALC) begin
			ea_q <= ea_d;
		end
	end

	// Address of the beat on offer
	always_ff @(posedge CLK_SYS) begin
		if (!RST_N) begin
			addr_q <= FPSQ_ADDR_RST;
		end else if (state_q == FPSQ_CALC) begin
			addr_q <= ea_d;
		end else if (first_ok) begin
			addr_q <= fpsq_addr_t'(ea_q + FPSQ_DW_STEP);
		end
	end

	// Second doubleword, held until the first beat is taken
	always_ff @(posedge CLK_SYS) begin
		if (!RST_N) begin
			data2_q <= FPSQ_DATA_RST;
		end else if (state_q == FPSQ_CALC) begin
			data2_q <= FPR_RD1_DATA;
		end
	end

	// Data of the beat on offer
	always_ff @(posedge CLK_SYS) begin
		if (!RST_N) begin
			data_q <= FPSQ_DATA_RST;
		end else if (state_q == FPSQ_CALC) begin
			if (dif.op == FPSQ_OP_IWX) begin
				// Low word, no conversion, even if single-rounded
				data_q <= {32'h0000_0000, FPR_RD0_DATA[31:0]};
			end else begin
				data_q <= FPR_RD0_DATA;
			end
		end else if (first_ok) begin
			data_q <= data2_q;
		end
	end

	// Word-size flag for the integer-word store
	always_ff @(posedge CLK_SYS) begin
		if (!RST_N) begin
			word_q <= 1'b0;
		end else if (state_q == FPSQ_CALC) begin
			word_q <= (dif.op == FPSQ_OP_IWX);
		end
	end

	// Sticky over both beats, so a fault on either cancels the update
	always_ff @(posedge CLK_SYS) begin
		if (!RST_N) begin
			fault_q <= 1'b0;
		end else if (state_q == FPSQ_CALC) begin
			fault_q <= 1'b0;
		end else if (beat_take && STORE_FAULT) begin
			fault_q <= 1'b1;
		end
	end

	// Store port straight from registers
	assign STORE_VALID = (state_q == FPSQ_ST0) || (state_q == FPSQ_ST1);
	assign STORE_ADDR = addr_q;
	assign STORE_DATA = data_q;
	assign STORE_WORD = word_q;

	// Only the base register is ever written; no status or CR0 path exists
	assign GPR_WE = fin && quad
		&& dif.upd && dif.base != 5'h00
		&& !fault_q;
	assign GPR_WR_IDX = dif.base;
	assign GPR_WR_DATA = ea_q;

	// Completion strobes, one cycle each
	assign DONE = fin;
	assign DONE_FAULT = fin && fault_q;
	assign DONE_ILLEGAL = fin && dif.op == FPSQ_OP_NONE;
endmodule : fpsq_unit

// >>> dv/fpsq_store_model.sv
`timescale 1ns/10ps
module fpsq_store_model (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic rst_n,
	// Store port
	input wire logic store_valid,
	input wire fpsq_pkg::fpsq_addr_t store_addr,
	output logic store_ready,
	output logic store_fault,
	// Behaviour knobs
	input wire logic [3:0] stall,
	input wire logic fault_en,
	input wire fpsq_pkg::fpsq_addr_t fault_addr
);
	import fpsq_pkg::*;
	logic [3:0] wait_q;
	// Counts stall cycles of the pending request
	always_ff @(posedge clk_sys) begin
		if (!rst_n || !store_valid || store_ready)
			wait_q <= 4'h0;
		else
			wait_q <= wait_q + 4'h1;
	end
	assign store_ready = store_valid && (wait_q >= stall);
	assign store_fault = store_ready && fault_en && (store_addr == fault_addr);
endmodule : fpsq_store_model

// >>> dv/fpsq_unit_checker.sv
`timescale 1ns/10ps
module fpsq_unit_checker (
	// Watched ports
	input wire logic CLK_SYS,
	input wire logic RST_N,
	input wire logic ISSUE_VALID,
	input wire logic ISSUE_READY,
	input wire logic STORE_VALID,
	input wire logic STORE_READY,
	input wire logic STORE_FAULT,
	input wire logic STORE_WORD,
	input wire fpsq_pkg::fpsq_addr_t STORE_ADDR,
	input wire fpsq_pkg::fpsq_fdata_t STORE_DATA,
	input wire logic GPR_WE,
	input wire fpsq_pkg::fpsq_ridx_t GPR_WR_IDX,
	input wire fpsq_pkg::fpsq_ridx_t GPR_BASE_IDX,
	input wire fpsq_pkg::fpsq_ridx_t FPR_RD0_IDX,
	input wire fpsq_pkg::fpsq_ridx_t FPR_RD1_IDX,
	input wire logic DONE,
	input wire logic DONE_FAULT,
	input wire logic DONE_ILLEGAL
);
	import fpsq_pkg::*;
	logic sec_q;
	fpsq_addr_t a0_q;
	default clocking @(posedge CLK_SYS); endclocking
	default disable iff (!RST_N);
	// Marks that the next doubleword is the second of a quad
	always_ff @(posedge CLK_SYS) begin
		if (!RST_N)
			sec_q <= 1'b0;
		else if (STORE_VALID && STORE_READY && !STORE_WORD)
			sec_q <= !sec_q && !STORE_FAULT;
	end
	always_ff @(posedge CLK_SYS) begin
		if (STORE_VALID && STORE_READY && !sec_q)
			a0_q <= STORE_ADDR;
	end
	property p_hold;
		STORE_VALID && !STORE_READY |=>
			STORE_VALID && $stable(STORE_ADDR) && $stable(STORE_DATA);
	endproperty
	a_hold: assert property (p_hold) else $error("store dropped");
	property p_word;
		STORE_VALID && STORE_WORD |-> STORE_DATA[63:32] == 32'h0;
	endproperty
	a_word: assert property (p_word) else $error("word upper");
	property p_step;
		STORE_VALID && sec_q |-> STORE_ADDR == a0_q + FPSQ_DW_STEP;
	endproperty
	a_step: assert property (p_step) else $error("second addr");
	property p_wrap;
		!ISSUE_READY |-> FPR_RD1_IDX == FPR_RD0_IDX + 5'h1;
	endproperty
	a_wrap: assert property (p_wrap) else $error("pair index");
	property p_wb;
		GPR_WE |-> DONE && !DONE_FAULT && GPR_WR_IDX != 5'h0
			&& GPR_WR_IDX == GPR_BASE_IDX;
	endproperty
	a_wb: assert property (p_wb) else $error("write-back");
	property p_flt;
		STORE_VALID && STORE_READY && STORE_FAULT |=> !STORE_VALID;
	endproperty
	a_flt: assert property (p_flt) else $error("store after fault");
	property p_take;
		ISSUE_VALID && ISSUE_READY |=> !ISSUE_READY [*2];
	endproperty
	a_take: assert property (p_take) else $error("busy");
	property p_ill;
		DONE_ILLEGAL |-> DONE && !GPR_WE && !DONE_FAULT;
	endproperty
	a_ill: assert property (p_ill) else $error("illegal side");
endmodule : fpsq_unit_checker
bind fpsq_unit fpsq_unit_checker fpsq_unit_checker_inst (
	.CLK_SYS(CLK_SYS),
	.RST_N(RST_N),
	.ISSUE_VALID(ISSUE_VALID),
	.ISSUE_READY(ISSUE_READY),
	.STORE_VALID(STORE_VALID),
	.STORE_READY(STORE_READY),
	.STORE_FAULT(STORE_FAULT),
	.STORE_WORD(STORE_WORD),
	.STORE_ADDR(STORE_ADDR),
	.STORE_DATA(STORE_DATA),
	.GPR_WE(GPR_WE),
	.GPR_WR_IDX(GPR_WR_IDX),
	.GPR_BASE_IDX(GPR_BASE_IDX),
	.FPR_RD0_IDX(FPR_RD0_IDX),
	.FPR_RD1_IDX(FPR_RD1_IDX),
	.DONE(DONE),
	.DONE_FAULT(DONE_FAULT),
	.DONE_ILLEGAL(DONE_ILLEGAL)
);

// >>> dv/fpsq_unit_tb_top.sv
`timescale 1ns/10ps
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin err_total++; \
	$display("[ERR] %0t got %h exp %h", $time, a, b); end end
module fpsq_unit_tb_top;
	import fpsq_pkg::*;
	logic CLK_SYS, RST_N, ISSUE_VALID, ISSUE_READY, STORE_VALID, STORE_READY;
	logic STORE_FAULT, STORE_WORD, GPR_WE, DONE, DONE_FAULT, DONE_ILLEGAL;
	logic [31:0] ISSUE_INSTR;
	fpsq_ridx_t GPR_BASE_IDX, GPR_INDEX_IDX, FPR_RD0_IDX, FPR_RD1_IDX, GPR_WR_IDX;
	fpsq_addr_t GPR_BASE_DATA, GPR_INDEX_DATA, STORE_ADDR, GPR_WR_DATA, fa, wb;
	fpsq_fdata_t FPR_RD0_DATA, FPR_RD1_DATA, STORE_DATA;
	fpsq_ridx_t wi;
	fpsq_addr_t gpr [32];
	fpsq_fdata_t fpr [32];
	fpsq_addr_t sa[$];
	fpsq_fdata_t sd[$];
	logic [3:0] stall;
	logic fe, sw;
	int err_total, n_compared, nwe;
	assign GPR_BASE_DATA = gpr[GPR_BASE_IDX];
	assign GPR_INDEX_DATA = gpr[GPR_INDEX_IDX];
	assign FPR_RD0_DATA = fpr[FPR_RD0_IDX];
	assign FPR_RD1_DATA = fpr[FPR_RD1_IDX];
	fpsq_unit fpsq_unit_inst (
		.CLK_SYS(CLK_SYS),
		.RST_N(RST_N),
		.ISSUE_VALID(ISSUE_VALID),
		.ISSUE_READY(ISSUE_READY),
		.ISSUE_INSTR(ISSUE_INSTR),
		.GPR_BASE_IDX(GPR_BASE_IDX),
		.GPR_BASE_DATA(GPR_BASE_DATA),
		.GPR_INDEX_IDX(GPR_INDEX_IDX),
		.GPR_INDEX_DATA(GPR_INDEX_DATA),
		.FPR_RD0_IDX(FPR_RD0_IDX),
		.FPR_RD0_DATA(FPR_RD0_DATA),
		.FPR_RD1_IDX(FPR_RD1_IDX),
		.FPR_RD1_DATA(FPR_RD1_DATA),
		.STORE_VALID(STORE_VALID),
		.STORE_READY(STORE_READY),
		.STORE_FAULT(STORE_FAULT),
		.STORE_ADDR(STORE_ADDR),
		.STORE_DATA(STORE_DATA),
		.STORE_WORD(STORE_WORD),
		.GPR_WE(GPR_WE),
		.GPR_WR_IDX(GPR_WR_IDX),
		.GPR_WR_DATA(GPR_WR_DATA),
		.DONE(DONE),
		.DONE_FAULT(DONE_FAULT),
		.DONE_ILLEGAL(DONE_ILLEGAL)
	);
	fpsq_store_model fpsq_store_model_inst (.clk_sys(CLK_SYS), .rst_n(RST_N),
		.store_valid(STORE_VALID), .store_addr(STORE_ADDR),
		.store_ready(STORE_READY), .store_fault(STORE_FAULT), .stall(stall),
		.fault_en(fe), .fault_addr(fa));
	initial begin
		CLK_SYS = 1'b0;
		forever #20 CLK_SYS = ~CLK_SYS;
	end
	always @(posedge CLK_SYS) begin
		if (STORE_VALID && STORE_READY) begin
			sa.push_back(STORE_ADDR);
			sd.push_back(STORE_DATA);
			sw = STORE_WORD;
		end
		if (GPR_WE) begin
			nwe++;
			wb = GPR_WR_DATA;
			wi = GPR_WR_IDX;
		end
	end
	function automatic logic [31:0] xf(fpsq_ridx_t f, a, b, logic [9:0] x);
		return {FPSQ_OPC_EXT, f, a, b, x, 1'b0};
	endfunction : xf
	function automatic logic [31:0] df(logic [5:0] o, fpsq_ridx_t f, a,
		logic [13:0] d, logic [1:0] s);
		return {o, f, a, d, s};
	endfunction : df
	task automatic go(input logic [31:0] ins, input logic ef, ei);
		int n;
		sa.delete();
		sd.delete();
		nwe = 0;
		@(posedge CLK_SYS);
		ISSUE_VALID <= 1'b1;
		ISSUE_INSTR <= ins;
		@(posedge CLK_SYS);
		ISSUE_VALID <= 1'b0;
		for (n = 0; n < 40 && DONE !== 1'b1; n++)
			@(negedge CLK_SYS);
		`CHK(DONE, 1'b1)
		`CHK(DONE_FAULT, ef)
		`CHK(DONE_ILLEGAL, ei)
		@(negedge CLK_SYS);
	endtask : go
	task automatic t_iwx;
		go(xf(5'h06, 5'h03, 5'h04, FPSQ_XO_IWX), 1'b0, 1'b0);
		`CHK(sa.size(), 1)
		`CHK(sa[0], 32'h0000_1008)
		`CHK(sd[0], 64'h0000_0000_6F20_776F)
		`CHK(sw, 1'b1)
		go(xf(5'h06, 5'h00, 5'h04, FPSQ_XO_IWX), 1'b0, 1'b0);
		`CHK(sa[0], 32'h0000_0008)
		`CHK(nwe, 0)
		$display("t_iwx done");
	endtask : t_iwx
	task automatic t_qd;
		stall = 4'h2;
		go(df(FPSQ_OPC_QD, 5'h1F, 5'h05, 14'h3FFF, FPSQ_SUB_QD), 1'b0, 1'b0);
		`CHK(sa[0], 32'h0000_1FFC)
		`CHK(sa[1], 32'h0000_2004)
		`CHK(sd[0], fpr[31])
		`CHK(sd[1], fpr[0])
		`CHK(nwe, 0)
		stall = 4'h0;
		$display("t_qd done");
	endtask : t_qd
	task automatic t_qdu;
		go(df(FPSQ_OPC_QDU, 5'h02, 5'h00, 14'h1FFF, FPSQ_SUB_QDU), 1'b0, 1'b0);
		`CHK(sa[0], 32'h0000_7FFC)
		`CHK(nwe, 0)
		go(df(FPSQ_OPC_QDU, 5'h02, 5'h05, 14'h0002, FPSQ_SUB_QDU), 1'b0, 1'b0);
		`CHK(nwe, 1)
		`CHK(wb, 32'h0000_2008)
		`CHK(wi, 5'h05)
		$display("t_qdu done");
	endtask : t_qdu
	task automatic t_qux;
		fe = 1'b1;
		fa = 32'h0000_3008;
		go(xf(5'h01, 5'h07, 5'h08, FPSQ_XO_QUX), 1'b1, 1'b0);
		`CHK(sa.size(), 2)
		`CHK(nwe, 0)
		fa = 32'h0000_3000;
		go(xf(5'h01, 5'h07, 5'h08, FPSQ_XO_QUX), 1'b1, 1'b0);
		`CHK(sa.size(), 1)
		fe = 1'b0;
		go(xf(5'h01, 5'h07, 5'h08, FPSQ_XO_QUX), 1'b0, 1'b0);
		`CHK(wb, 32'h0000_3000)
		$display("t_qux done");
	endtask : t_qux
	task automatic t_ill;
		go(df(FPSQ_OPC_QD, 5'h01, 5'h05, 14'h0, FPSQ_SUB_QDU), 1'b0, 1'b1);
		go(df(FPSQ_OPC_QDU, 5'h01, 5'h05, 14'h0, FPSQ_SUB_QD), 1'b0, 1'b1);
		`CHK(sa.size() + nwe, 0)
		$display("t_ill done");
	endtask : t_ill
	task automatic wrap_up;
		$display("compared %0d mismatches %0d", n_compared, err_total);
		if (err_total == 0 && n_compared > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : wrap_up
	initial begin
		#80000;
		err_total++;
		wrap_up();
	end
	initial begin
		{RST_N, ISSUE_VALID, fe, stall, fa, ISSUE_INSTR} = '0;
		for (int i = 0; i < 32; i++) begin
			gpr[i] = 32'h0;
			fpr[i] = {2{24'h5A5A5A, 3'h0, 5'(i)}};
		end
		{gpr[3], gpr[4], gpr[5], gpr[7]} = {32'h1000, 32'h8, 32'h2000, 32'h3000};
		fpr[6] = 64'h4865_6C6C_6F20_776F;
		repeat (3) @(posedge CLK_SYS);
		RST_N <= 1'b1;
		t_iwx();
		t_qd();
		t_qdu();
		t_qux();
		t_ill();
		wrap_up();
	end
endmodule : fpsq_unit_tb_top
